// [src/sdsc_ctrl.sv]
// Socket distributed-channel slave control: registers and transfer sequencing
`timescale 1ns/1ps
module sdsc_ctrl
   import sdsc_pkg::*;
#(
   parameter int CNT_W = 16
)
(
   input  wire logic        core_clk_i,     // Clock
   input  wire logic        rst_i,          // Async reset, active high
   input  wire logic [3:0]  reg_addr_i,     // Window offset
   input  wire logic        reg_wr_i,       // Write strobe
   input  wire logic        reg_rd_i,       // Read strobe
   input  wire logic [7:0]  reg_wdata_i,    // Write data
   output logic      [7:0]  reg_rdata_o,    // Read data
   input  wire logic        card_dreq_i,    // Card request line
   input  wire logic        card_present_i, // Card in socket
   input  wire logic        xfer_ack_i,     // One transfer completed
   input  wire logic        xfer_wide_i,    // 16-bit transfer mode
   output logic             dma_req_o,      // Request to host master
   output logic             dma_mem_wr_o,   // Card to memory direction
   output logic      [23:0] dma_addr_o,     // Page and current address
   output logic             tc_o            // Terminal count pulse
);
   logic             wr_status;
   logic             wr_request;
   logic             wr_mode;
   logic             wr_mask;
   logic             mclr;
   logic             rd_status;
   logic             dreq_ok;
   logic             go;
   logic             xfer_done;
   logic             tc_evt;
   logic             rearm;
   logic [15:0]      next_addr;
   logic [CNT_W-1:0] next_cnt;
   logic             last;
   logic [7:0]       rdata_nxt;
   logic [15:0]      base_addr_r;
   logic [15:0]      cur_addr_r;
   logic [7:0]       page_r;
   logic [CNT_W-1:0] base_cnt_r;
   logic [CNT_W-1:0] cur_cnt_r;
   logic             ctrl_dis_r;
   logic [1:0]       xfer_mode_r;
   logic             addr_dir_r;
   logic             auto_rel_r;
   logic [1:0]       xfer_type_r;
   logic             mask_r;
   logic             present_r;
   logic [3:0]       tc_flag_r;
   logic             sw_req_r;
   sdsc_state_e      state_r;
   sdsc_state_e      state_nxt;

   // Register strobes
   always_comb
   begin
      wr_status  = reg_wr_i && (reg_addr_i == SDSC_OFS_STATUS);
      wr_request = reg_wr_i && (reg_addr_i == SDSC_OFS_REQUEST);
      wr_mode    = reg_wr_i && (reg_addr_i == SDSC_OFS_MODE);
      wr_mask    = reg_wr_i && (reg_addr_i == SDSC_OFS_MASK);
      mclr       = reg_wr_i && (reg_addr_i == SDSC_OFS_MCLR);
      rd_status  = reg_rd_i && (reg_addr_i == SDSC_OFS_STATUS);
   end

   sdsc_xfer_step #(
      .CNT_W (CNT_W)
   ) u_step (
      .cur_addr_i  (cur_addr_r),
      .cur_cnt_i   (cur_cnt_r),
      .addr_down_i (addr_dir_r),
      .wide_i      (xfer_wide_i),
      .next_addr_o (next_addr),
      .next_cnt_o  (next_cnt),
      .last_o      (last)
   );

   // Channel qualification
   always_comb
   begin
      dreq_ok   = card_dreq_i && !mask_r;
      go        = !ctrl_dis_r
                  && (xfer_type_r != SDSC_XT_NONE)
                  && (xfer_mode_r != SDSC_XM_RSVD);
      xfer_done = (state_r == SDSC_RUN) && xfer_ack_i;
      tc_evt    = xfer_done && last;
      rearm     = reg_wr_i && (reg_addr_i == SDSC_OFS_ADDR_LO
                  || reg_addr_i == SDSC_OFS_ADDR_HI
                  || reg_addr_i == SDSC_OFS_CNT_LO
                  || reg_addr_i == SDSC_OFS_CNT_HI
                  || reg_addr_i == SDSC_OFS_MODE);
   end

   // Transfer sequencing
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         SDSC_IDLE:
            if (go && (dreq_ok
                || (xfer_mode_r == SDSC_XM_BLOCK && sw_req_r)))
               state_nxt = SDSC_RUN;
         SDSC_RUN:
         begin
            if (!go)
               state_nxt = SDSC_IDLE;
            else if (tc_evt)
               state_nxt = auto_rel_r ? SDSC_IDLE : SDSC_HALT;
            else if (xfer_done && xfer_mode_r == SDSC_XM_SINGLE)
               state_nxt = SDSC_GAP;
            else if (xfer_mode_r == SDSC_XM_DEMAND && !dreq_ok)
               state_nxt = SDSC_IDLE;
         end
         SDSC_GAP:
            if (!card_dreq_i || !go)
               state_nxt = SDSC_IDLE;
         SDSC_HALT:
            if (rearm)
               state_nxt = SDSC_IDLE;
         default:
            state_nxt = SDSC_IDLE;
      endcase
      if (mclr)
         state_nxt = SDSC_IDLE;
   end

   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         state_r   <= SDSC_IDLE;
         dma_req_o <= 1'b0;
      end
      else
      begin
         state_r   <= state_nxt;
         dma_req_o <= (state_nxt == SDSC_RUN);
      end
   end

   // Software request, dropped at terminal count
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
         sw_req_r <= 1'b0;
      else if (mclr || tc_evt)
         sw_req_r <= 1'b0;
      else if (wr_request)
         sw_req_r <= 1'b1;
   end

   // Command register
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
         ctrl_dis_r <= SDSC_DIS_RST;
      else if (mclr)
         ctrl_dis_r <= SDSC_DIS_RST;
      else if (wr_status)
         ctrl_dis_r <= reg_wdata_i[SDSC_CMD_DIS_BIT];
   end

   // Mode register
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         xfer_mode_r <= SDSC_XM_DEMAND;
         addr_dir_r  <= 1'b0;
         auto_rel_r  <= 1'b0;
         xfer_type_r <= SDSC_XT_NONE;
      end
      else if (mclr)
      begin
         xfer_mode_r <= SDSC_XM_DEMAND;
         addr_dir_r  <= 1'b0;
         auto_rel_r  <= 1'b0;
         xfer_type_r <= SDSC_XT_NONE;
      end
      else if (wr_mode)
      begin
         xfer_mode_r <= reg_wdata_i[SDSC_MODE_SEL_MSB:SDSC_MODE_SEL_LSB];
         addr_dir_r  <= reg_wdata_i[SDSC_MODE_DIR_BIT];
         auto_rel_r  <= reg_wdata_i[SDSC_MODE_AUTO_BIT];
         xfer_type_r <= reg_wdata_i[SDSC_MODE_TYPE_MSB:SDSC_MODE_TYPE_LSB];
      end
   end

   // Mask bit: removal sets it and wins over a software write
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         mask_r    <= SDSC_MASK_RST;
         present_r <= 1'b0;
      end
      else
      begin
         present_r <= card_present_i;
         if (present_r && !card_present_i)
            mask_r <= 1'b1;
         else if (mclr)
            mask_r <= SDSC_MASK_RST;
         else if (wr_mask)
            mask_r <= reg_wdata_i[SDSC_MASK_BIT];
      end
   end

   // Terminal count flags: set wins over clear on read
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
         tc_flag_r <= SDSC_NIB_ZERO;
      else if (tc_evt)
         tc_flag_r <= SDSC_NIB_ONES;
      else if (mclr || rd_status)
         tc_flag_r <= SDSC_NIB_ZERO;
   end

   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
         tc_o <= 1'b0;
      else
         tc_o <= tc_evt;
   end

   // Address and page registers
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         base_addr_r <= SDSC_WORD_RST;
         cur_addr_r  <= SDSC_WORD_RST;
         page_r      <= SDSC_BYTE_RST;
      end
      else if (mclr)
      begin
         base_addr_r <= SDSC_WORD_RST;
         cur_addr_r  <= SDSC_WORD_RST;
         page_r      <= SDSC_BYTE_RST;
      end
      else if (reg_wr_i && reg_addr_i == SDSC_OFS_ADDR_LO)
      begin
         base_addr_r[7:0] <= reg_wdata_i;
         cur_addr_r       <= {base_addr_r[15:8], reg_wdata_i};
      end
      else if (reg_wr_i && reg_addr_i == SDSC_OFS_ADDR_HI)
      begin
         base_addr_r[15:8] <= reg_wdata_i;
         cur_addr_r        <= {reg_wdata_i, base_addr_r[7:0]};
      end
      else if (reg_wr_i && reg_addr_i == SDSC_OFS_PAGE)
         page_r <= reg_wdata_i;
      else if (tc_evt && auto_rel_r)
         cur_addr_r <= base_addr_r;
      else if (xfer_done)
         cur_addr_r <= next_addr;
   end

   // Count registers
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         base_cnt_r <= SDSC_WORD_RST[CNT_W-1:0];
         cur_cnt_r  <= SDSC_WORD_RST[CNT_W-1:0];
      end
      else if (mclr)
      begin
         base_cnt_r <= SDSC_WORD_RST[CNT_W-1:0];
         cur_cnt_r  <= SDSC_WORD_RST[CNT_W-1:0];
      end
      else if (reg_wr_i && reg_addr_i == SDSC_OFS_CNT_LO)
      begin
         base_cnt_r[7:0] <= reg_wdata_i;
         cur_cnt_r       <= {base_cnt_r[CNT_W-1:8], reg_wdata_i};
      end
      else if (reg_wr_i && reg_addr_i == SDSC_OFS_CNT_HI)
      begin
         base_cnt_r[15:8] <= reg_wdata_i;
         cur_cnt_r        <= {reg_wdata_i, base_cnt_r[7:0]};
      end
      else if (tc_evt && auto_rel_r)
         cur_cnt_r <= base_cnt_r;
      else if (xfer_done)
         cur_cnt_r <= next_cnt;
   end

   // Read data mux
   always_comb
   begin
      rdata_nxt = SDSC_BYTE_RST;
      case (reg_addr_i)
         SDSC_OFS_ADDR_LO: rdata_nxt = cur_addr_r[7:0];
         SDSC_OFS_ADDR_HI: rdata_nxt = cur_addr_r[15:8];
         SDSC_OFS_PAGE:    rdata_nxt = page_r;
         SDSC_OFS_CNT_LO:  rdata_nxt = cur_cnt_r[7:0];
         SDSC_OFS_CNT_HI:  rdata_nxt = cur_cnt_r[15:8];
         SDSC_OFS_STATUS:
         begin
            rdata_nxt[SDSC_STAT_REQ_LSB +: 4] =
               card_dreq_i ? SDSC_NIB_ONES : SDSC_NIB_ZERO;
            rdata_nxt[SDSC_STAT_TC_LSB +: 4] = tc_flag_r;
         end
         SDSC_OFS_MODE:
         begin
            rdata_nxt[SDSC_MODE_SEL_MSB:SDSC_MODE_SEL_LSB] = xfer_mode_r;
            rdata_nxt[SDSC_MODE_DIR_BIT] = addr_dir_r;
            rdata_nxt[SDSC_MODE_AUTO_BIT] = auto_rel_r;
            rdata_nxt[SDSC_MODE_TYPE_MSB:SDSC_MODE_TYPE_LSB] = xfer_type_r;
            // Bits 1-0 stay zero
         end
         SDSC_OFS_MASK:
            rdata_nxt[SDSC_MASK_BIT] = mask_r;
         default:
            rdata_nxt = SDSC_BYTE_RST;
      endcase
   end

   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
         reg_rdata_o <= SDSC_BYTE_RST;
      else if (reg_rd_i)
         reg_rdata_o <= rdata_nxt;
   end

   // Outbound transfer attributes
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         dma_mem_wr_o <= 1'b0;
         dma_addr_o   <= {SDSC_BYTE_RST, SDSC_WORD_RST};
      end
      else
      begin
         dma_mem_wr_o <= (xfer_type_r == SDSC_XT_MEMWR);
         dma_addr_o   <= {page_r, cur_addr_r};
      end
   end
endmodule

// [src/sdsc_pkg.sv]
// Constants and types for the socket distributed-channel slave control
package sdsc_pkg;
   // Register window offsets
   localparam logic [3:0] SDSC_OFS_ADDR_LO  = 4'h0;
   localparam logic [3:0] SDSC_OFS_ADDR_HI  = 4'h1;
   localparam logic [3:0] SDSC_OFS_PAGE     = 4'h2;
   localparam logic [3:0] SDSC_OFS_CNT_LO   = 4'h4;
   localparam logic [3:0] SDSC_OFS_CNT_HI   = 4'h5;
   localparam logic [3:0] SDSC_OFS_STATUS   = 4'h8;
   localparam logic [3:0] SDSC_OFS_REQUEST  = 4'h9;
   localparam logic [3:0] SDSC_OFS_MODE     = 4'hb;
   localparam logic [3:0] SDSC_OFS_MCLR     = 4'hd;
   localparam logic [3:0] SDSC_OFS_MASK     = 4'hf;

   // Field positions
   localparam int SDSC_STAT_REQ_LSB  = 4;
   localparam int SDSC_STAT_TC_LSB   = 0;
   localparam int SDSC_CMD_DIS_BIT   = 2;
   localparam int SDSC_MODE_SEL_MSB  = 7;
   localparam int SDSC_MODE_SEL_LSB  = 6;
   localparam int SDSC_MODE_DIR_BIT  = 5;
   localparam int SDSC_MODE_AUTO_BIT = 4;
   localparam int SDSC_MODE_TYPE_MSB = 3;
   localparam int SDSC_MODE_TYPE_LSB = 2;
   localparam int SDSC_MASK_BIT      = 0;

   // Reset values and the all-ones flag nibble
   localparam logic [7:0]  SDSC_BYTE_RST  = 8'h00;
   localparam logic [15:0] SDSC_WORD_RST  = 16'h0000;
   localparam logic [1:0]  SDSC_FIELD_RST = 2'h0;
   localparam logic        SDSC_MASK_RST  = 1'b1;
   localparam logic        SDSC_DIS_RST   = 1'b0;
   localparam logic [3:0]  SDSC_NIB_ONES  = 4'hf;
   localparam logic [3:0]  SDSC_NIB_ZERO  = 4'h0;

   // Transfer mode and type encodings
   localparam logic [1:0] SDSC_XM_DEMAND = 2'h0;
   localparam logic [1:0] SDSC_XM_SINGLE = 2'h1;
   localparam logic [1:0] SDSC_XM_BLOCK  = 2'h2;
   localparam logic [1:0] SDSC_XM_RSVD   = 2'h3;
   localparam logic [1:0] SDSC_XT_NONE   = 2'h0;
   localparam logic [1:0] SDSC_XT_MEMWR  = 2'h1;
   localparam logic [1:0] SDSC_XT_MEMRD  = 2'h2;

   // Per-transfer steps
   localparam logic [15:0] SDSC_CNT_STEP8  = 16'h0001;
   localparam logic [15:0] SDSC_CNT_STEP16 = 16'h0002;
   localparam logic [15:0] SDSC_ADDR_STEP  = 16'h0001;

   typedef enum logic [1:0] {
      SDSC_IDLE,
      SDSC_RUN,
      SDSC_GAP,
      SDSC_HALT
   } sdsc_state_e;
endpackage

// [src/sdsc_xfer_step.sv]
// Next address and count after one completed transfer
`timescale 1ns/1ps
module sdsc_xfer_step
   import sdsc_pkg::*;
#(
   parameter int CNT_W = 16
)
(
   input  wire logic [15:0]      cur_addr_i,  // Current address
   input  wire logic [CNT_W-1:0] cur_cnt_i,   // Current byte count
   input  wire logic             addr_down_i, // Address steps downward
   input  wire logic             wide_i,      // 16-bit transfer mode
   output logic      [15:0]      next_addr_o, // Address after transfer
   output logic      [CNT_W-1:0] next_cnt_o,  // Count after transfer
   output logic                  last_o       // Transfer ends the count
);
   logic [CNT_W-1:0] step;

   always_comb
   begin
      step = wide_i ? SDSC_CNT_STEP16[CNT_W-1:0] : SDSC_CNT_STEP8[CNT_W-1:0];
      next_cnt_o = cur_cnt_i - step;
      last_o = (cur_cnt_i <= step);
      if (addr_down_i)
         next_addr_o = cur_addr_i - SDSC_ADDR_STEP;
      else
         next_addr_o = cur_addr_i + SDSC_ADDR_STEP;
   end
endmodule

// [verif/sdsc_ctrl_chk.sv]
// Concurrent checks on the slave control ports
`timescale 1ns/1ps
module sdsc_ctrl_chk
   import sdsc_pkg::*;
#(
   parameter int CNT_W = 16
)
(
   input wire logic        core_clk_i,     // Clock
   input wire logic        rst_i,          // Reset
   input wire logic [3:0]  reg_addr_i,     // Offset
   input wire logic        reg_wr_i,       // Write
   input wire logic        reg_rd_i,       // Read
   input wire logic [7:0]  reg_wdata_i,    // Write data
   input wire logic [7:0]  reg_rdata_o,    // Read data
   input wire logic        card_dreq_i,    // Card request
   input wire logic        card_present_i, // Card present
   input wire logic        xfer_ack_i,     // Transfer done
   input wire logic        xfer_wide_i,    // Wide mode
   input wire logic        dma_req_o,      // Channel request
   input wire logic        dma_mem_wr_o,   // Memory write
   input wire logic [23:0] dma_addr_o,     // Address
   input wire logic        tc_o            // Terminal count
);
   default clocking dc @(posedge core_clk_i);
   endclocking
   default disable iff (rst_i);

   req_status_a:
      assert property (reg_rd_i && reg_addr_i == SDSC_OFS_STATUS
         |=> reg_rdata_o[7:4] == {4{$past(card_dreq_i)}})
      else $error("request status bits wrong");
   tc_group_a:
      assert property (reg_rd_i && reg_addr_i == SDSC_OFS_STATUS
         |=> reg_rdata_o[3:0] == SDSC_NIB_ZERO
         || reg_rdata_o[3:0] == SDSC_NIB_ONES)
      else $error("count flags split");
   tc_clear_a:
      assert property ((reg_rd_i && reg_addr_i == SDSC_OFS_STATUS
         && !dma_req_o) ##1 (!reg_rd_i && !dma_req_o)
         ##1 (reg_rd_i && reg_addr_i == SDSC_OFS_STATUS && !dma_req_o)
         |=> reg_rdata_o[3:0] == SDSC_NIB_ZERO)
      else $error("count flags not cleared by read");
   mode_low_a:
      assert property (reg_rd_i && reg_addr_i == SDSC_OFS_MODE
         |=> reg_rdata_o[1:0] == 2'h0)
      else $error("mode low bits not zero");
   mask_high_a:
      assert property (reg_rd_i && reg_addr_i == SDSC_OFS_MASK
         |=> reg_rdata_o[7:1] == 7'h00)
      else $error("mask upper bits not zero");
   mask_fall_a:
      assert property ($fell(card_present_i)
         ##1 (reg_rd_i && reg_addr_i == SDSC_OFS_MASK)
         |=> reg_rdata_o[0])
      else $error("removal did not set mask");
   tc_pulse_a:
      assert property (tc_o
         |-> ($past(xfer_ack_i) && $past(dma_req_o)) ##1 !tc_o)
      else $error("terminal pulse without ack");
   mclr_idle_a:
      assert property (reg_wr_i && reg_addr_i == SDSC_OFS_MCLR
         |-> ##2 (!dma_req_o && dma_addr_o == 24'h00_0000))
      else $error("master clear left channel busy");
   mem_wr_a:
      assert property (reg_wr_i && reg_addr_i == SDSC_OFS_MODE
         |-> ##2 dma_mem_wr_o == ($past(reg_wdata_i[3:2], 2)
         == SDSC_XT_MEMWR))
      else $error("direction output wrong");
endmodule

bind sdsc_ctrl sdsc_ctrl_chk #(.CNT_W(CNT_W)) u_sdsc_ctrl_chk (
   .core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
   .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
   .reg_rdata_o(reg_rdata_o), .card_dreq_i(card_dreq_i),
   .card_present_i(card_present_i), .xfer_ack_i(xfer_ack_i),
   .xfer_wide_i(xfer_wide_i), .dma_req_o(dma_req_o),
   .dma_mem_wr_o(dma_mem_wr_o), .dma_addr_o(dma_addr_o), .tc_o(tc_o)
);

// [verif/sdsc_far_model.sv]
// Card and host master stand-in: request lines and transfer acks
`timescale 1ns/1ps
module sdsc_far_model
(
   input  wire logic clk_i,     // Clock
   input  wire logic rst_i,     // Reset
   input  wire logic dreq_i,    // Wanted request
   input  wire logic present_i, // Wanted presence
   input  wire logic ack_en_i,  // Master answers
   input  wire logic slow_i,    // Master answers late
   input  wire logic dma_req_i, // Channel request
   output logic      dreq_o,    // Card request
   output logic      present_o, // Card present
   output logic      ack_o      // Transfer done
);
   logic [1:0] wait_r;

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         dreq_o    <= 1'b0;
         present_o <= 1'b1;
      end
      else
      begin
         dreq_o    <= dreq_i;
         present_o <= present_i;
      end
   end

   // One ack at most every second request cycle, never twice in a row
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         ack_o  <= 1'b0;
         wait_r <= 2'h0;
      end
      else
      begin
         ack_o <= 1'b0;
         if (ack_en_i && dma_req_i && !ack_o)
         begin
            if (!slow_i || wait_r == 2'h3)
            begin
               ack_o  <= 1'b1;
               wait_r <= 2'h0;
            end
            else
               wait_r <= wait_r + 2'h1;
         end
      end
   end
endmodule

// [verif/socket_dma_slave_control_tb.sv]
// Self-checking bench for the slave control
`timescale 1ns/1ps
module socket_dma_slave_control_tb;
   import sdsc_pkg::*;
   logic        clk, rst, rd, wr, wide, dq, pr, ae, sl;
   logic        dreq, pres, ack, req, mwr, tc;
   logic [3:0]  ad;
   logic [7:0]  wd, rdat, q;
   logic [23:0] addr;
   int          errors, compares, acks;
   logic [19:0] rows [6] = '{
      20'hb_b7b4,
      20'hb_5a58,
      20'hb_2b28,
      20'h3_ff00,
      20'hf_fe00,
      20'hf_ff01
   };

   sdsc_ctrl u_sdsc_ctrl (
      .core_clk_i(clk), .rst_i(rst), .reg_addr_i(ad), .reg_wr_i(wr),
      .reg_rd_i(rd), .reg_wdata_i(wd), .reg_rdata_o(rdat),
      .card_dreq_i(dreq), .card_present_i(pres), .xfer_ack_i(ack),
      .xfer_wide_i(wide), .dma_req_o(req), .dma_mem_wr_o(mwr),
      .dma_addr_o(addr), .tc_o(tc)
   );
   sdsc_far_model u_sdsc_far_model (
      .clk_i(clk), .rst_i(rst), .dreq_i(dq), .present_i(pr),
      .ack_en_i(ae), .slow_i(sl), .dma_req_i(req), .dreq_o(dreq),
      .present_o(pres), .ack_o(ack)
   );

   always @(posedge clk)
   begin
      if (ack === 1'b1 && req === 1'b1)
         acks++;
   end

   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      compares++;
      if (seen !== exp)
      begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      ad <= a;
      wd <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk);
      rd <= 1'b1;
      ad <= a;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      chk({16'h0000, rdat}, {16'h0000, e});
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask
   task automatic wait_tc();
      int n;
      n = 0;
      while (tc !== 1'b1 && n < 300)
      begin
         @(negedge clk);
         n++;
      end
   endtask
   task end_of_test();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial
   begin
      #2_000_000;
      errors++;
      end_of_test();
   end

   initial
   begin
      rst = 1'b1;
      {rd, wr, wide, dq, ae, sl} = 6'h00;
      pr = 1'b1;
      ad = 4'h0;
      wd = 8'h00;
      {errors, compares, acks} = '0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      rd_chk(SDSC_OFS_STATUS, 8'h00);
      rd_chk(SDSC_OFS_MODE, 8'h00);
      rd_chk(SDSC_OFS_MASK, 8'h01);
      for (int i = 0; i < 6; i++)
      begin
         wr_reg(rows[i][19:16], rows[i][15:8]);
         rd_chk(rows[i][19:16], rows[i][7:0]);
      end
      $display("test 1 done");
      wr_reg(SDSC_OFS_MODE, 8'h04);
      @(posedge clk) dq <= 1'b1;
      cyc(5);
      chk(req, 1'b0);
      rd_chk(SDSC_OFS_STATUS, 8'hf0);
      wr_reg(SDSC_OFS_MASK, 8'h00);
      cyc(5);
      chk(req, 1'b1);
      chk(mwr, 1'b1);
      wr_reg(SDSC_OFS_MODE, 8'hc4);
      cyc(2);
      chk(req, 1'b0);
      wr_reg(SDSC_OFS_MODE, 8'h04);
      cyc(2);
      chk(req, 1'b1);
      @(posedge clk) dq <= 1'b0;
      cyc(5);
      chk(req, 1'b0);
      rd_chk(SDSC_OFS_STATUS, 8'h00);
      $display("test 2 done");
      wr_reg(SDSC_OFS_MCLR, 8'h00);
      wr_reg(SDSC_OFS_CNT_LO, 8'h03);
      wr_reg(SDSC_OFS_ADDR_LO, 8'h10);
      wr_reg(SDSC_OFS_PAGE, 8'h12);
      wr_reg(SDSC_OFS_MODE, 8'h88);
      acks = 0;
      @(posedge clk) ae <= 1'b1;
      wr_reg(SDSC_OFS_REQUEST, 8'h3c);
      wait_tc();
      chk(tc, 1'b1);
      chk(24'(acks), 24'h00_0003);
      chk(mwr, 1'b0);
      cyc(1);
      chk(addr, 24'h12_0013);
      rd_chk(SDSC_OFS_STATUS, 8'h0f);
      rd_chk(SDSC_OFS_STATUS, 8'h00);
      @(posedge clk) ae <= 1'b0;
      $display("test 3 done");
      wr_reg(SDSC_OFS_MCLR, 8'h00);
      @(posedge clk) wide <= 1'b1;
      wr_reg(SDSC_OFS_CNT_LO, 8'h04);
      wr_reg(SDSC_OFS_ADDR_LO, 8'h20);
      wr_reg(SDSC_OFS_MODE, 8'hb4);
      acks = 0;
      @(posedge clk) ae <= 1'b1;
      wr_reg(SDSC_OFS_REQUEST, 8'h00);
      wait_tc();
      chk(tc, 1'b1);
      @(posedge clk) ae <= 1'b0;
      chk(24'(acks), 24'h00_0002);
      cyc(1);
      chk(addr, 24'h00_0020);
      wr_reg(SDSC_OFS_MCLR, 8'h00);
      rd_chk(SDSC_OFS_STATUS, 8'h00);
      @(posedge clk) wide <= 1'b0;
      $display("test 4 done");
      wr_reg(SDSC_OFS_MASK, 8'h00);
      @(posedge clk) pr <= 1'b0;
      @(posedge clk);
      rd_chk(SDSC_OFS_MASK, 8'h01);
      @(posedge clk) pr <= 1'b1;
      $display("test 5 done");
      wr_reg(SDSC_OFS_MODE, 8'h04);
      wr_reg(SDSC_OFS_MASK, 8'h00);
      wr_reg(SDSC_OFS_STATUS, 8'h04);
      @(posedge clk) dq <= 1'b1;
      cyc(5);
      chk(req, 1'b0);
      rd_chk(SDSC_OFS_STATUS, 8'hf0);
      wr_reg(SDSC_OFS_STATUS, 8'h00);
      cyc(3);
      chk(req, 1'b1);
      wr_reg(SDSC_OFS_MCLR, 8'h5a);
      cyc(1);
      chk(req, 1'b0);
      rd_chk(SDSC_OFS_MASK, 8'h01);
      @(posedge clk) dq <= 1'b0;
      $display("test 6 done");
      wr_reg(SDSC_OFS_CNT_LO, 8'h05);
      wr_reg(SDSC_OFS_MODE, 8'h44);
      wr_reg(SDSC_OFS_MASK, 8'h00);
      acks = 0;
      @(posedge clk) sl <= 1'b1;
      @(posedge clk) ae <= 1'b1;
      @(posedge clk) dq <= 1'b1;
      cyc(12);
      chk(24'(acks), 24'h00_0001);
      @(posedge clk) dq <= 1'b0;
      cyc(2);
      @(posedge clk) dq <= 1'b1;
      cyc(12);
      chk(24'(acks), 24'h00_0002);
      $display("test 7 done");
      end_of_test();
   end
endmodule
